// file: src/dgs_top.sv
// DDR edge I/O: output gearing, DLL strobe delay, read and write strobe control
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "dgs_defs.svh"
module dgs_top
  import dgs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Fabric data in {out_pos_data_a, out_neg_data_a, out_pos_data_b, out_neg_data_b}
  input wire logic out_pos_data_a,
  input wire logic out_neg_data_a,
  input wire logic out_pos_data_b,
  input wire logic out_neg_data_b,
  input wire logic in_valid,
  output logic in_ready,
  // Data pin
  output logic dq_out,
  output logic dq_oe_n,
  // Strobe pin
  input wire logic dqs_in,
  output logic dqs_out,
  output logic dqs_oe_n,
  // Strobe and gearing signals toward the I/O cells
  output logic write_gear_clk_a,
  output logic write_gear_clk_b,
  output logic read_strobe_delayed_clk,
  output logic capture_clock_polarity,
  output logic gearbox_transfer_latch,
  output logic write_strobe_clock
);

  function automatic dgs_mode_t eff_mode(input logic [1:0] req, input logic [1:0] edge_sel);
    dgs_mode_t m;
    m = dgs_mode_t'(req);
    if (m == DGS_RSV) begin
      m = DGS_SDR;
    end
    if (dgs_edge_t'(edge_sel) == DGS_BOTTOM) begin
      m = DGS_SDR;
    end else if (dgs_edge_t'(edge_sel) == DGS_TOP && m == DGS_GEAR) begin
      m = DGS_DDR;
    end
    return m;
  endfunction

  function automatic logic is_right(input logic [2:0] bank);
    return (bank == 3'h1) || (bank == 3'h2) || (bank == 3'h3);
  endfunction

  // Registers
  logic [31:0] ctrl_ff;
  logic [7:0] dynamic_delay_setting_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic apb_acc;
  logic [31:0] stat_word;
  dgs_mode_t mode;
  logic side_r;
  logic en;

  assign apb_acc = psel && penable && pready_ff;
  assign en = ctrl_ff[`DGS_F_EN];
  assign mode = eff_mode(ctrl_ff[1:0], ctrl_ff[`DGS_F_EDGE_LO +: 2]);
  assign side_r = is_right(ctrl_ff[`DGS_F_BANK_LO +: 3]);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= psel && penable && !pready_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata_ff <= 32'h0;
      pslverr_ff <= 1'b0;
    end else if (psel && penable && !pready_ff) begin
      prdata_ff <= 32'h0;
      pslverr_ff <= 1'b0;
      if (paddr == `DGS_ADDR_CTRL) begin
        prdata_ff <= pwrite ? 32'h0 : ctrl_ff;
      end else if (paddr == `DGS_ADDR_DYN) begin
        prdata_ff <= pwrite ? 32'h0 : {24'h0, dynamic_delay_setting_ff};
      end else if (paddr == `DGS_ADDR_STAT) begin
        prdata_ff <= pwrite ? 32'h0 : stat_word;
        pslverr_ff <= pwrite;
      end else begin
        pslverr_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_ff <= `DGS_CTRL_RST;
      dynamic_delay_setting_ff <= `DGS_DYN_RST;
    end else if (apb_acc && pwrite) begin
      if (paddr == `DGS_ADDR_CTRL) begin
        ctrl_ff <= {23'h0, pwdata[8:0]};
      end else if (paddr == `DGS_ADDR_DYN) begin
        dynamic_delay_setting_ff <= pwdata[7:0];
      end
    end
  end

  // Two-entry buffer ahead of the serialiser
  logic [3:0] buf_mem [2];
  logic wr_ptr_ff;
  logic rd_ptr_ff;
  logic [1:0] cnt_ff;
  logic in_ready_ff;
  logic push;
  logic pop;
  logic [3:0] head;
  logic [1:0] nxt_cnt;

  assign push = in_valid && in_ready_ff;
  assign head = buf_mem[rd_ptr_ff];

  always_comb begin
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 2'h1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      cnt_ff <= 2'h0;
      in_ready_ff <= 1'b0;
    end else begin
      wr_ptr_ff <= wr_ptr_ff ^ push;
      rd_ptr_ff <= rd_ptr_ff ^ pop;
      cnt_ff <= nxt_cnt;
      in_ready_ff <= nxt_cnt != 2'h2;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      buf_mem[wr_ptr_ff] <= {out_pos_data_a, out_neg_data_a, out_pos_data_b, out_neg_data_b};
    end
  end

  // Gearing clocks: {b, a} walk the serialiser phase
  logic gclk_a_ff;
  logic gclk_b_ff;
  logic [1:0] ph;

  assign ph = {gclk_b_ff, gclk_a_ff};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gclk_a_ff <= 1'b0;
      gclk_b_ff <= 1'b0;
    end else begin
      gclk_a_ff <= !gclk_a_ff;
      gclk_b_ff <= gclk_b_ff ^ gclk_a_ff;
    end
  end

  // Output register block
  logic [3:0] gear_ff;
  logic [1:0] hold_ff;
  logic dq_out_ff;
  logic dq_oe_n_ff;
  logic word_vld_ff;
  logic slot;

  always_comb begin
    if (mode == DGS_SDR) begin
      // Latch mode takes a word only in the transparent half
      slot = !ctrl_ff[`DGS_F_LATCH] || gclk_a_ff;
    end else if (mode == DGS_DDR) begin
      slot = !ph[0];
    end else begin
      slot = ph == 2'h0;
    end
  end

  assign pop = en && slot && (cnt_ff != 2'h0);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gear_ff <= 4'h0;
      word_vld_ff <= 1'b0;
    end else if (slot) begin
      if (pop) begin
        gear_ff <= head;
      end
      word_vld_ff <= pop;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold_ff <= 2'h0;
    end else if ((mode == DGS_DDR && ph[0]) || (mode == DGS_GEAR && ph == 2'h1)) begin
      hold_ff[0] <= gear_ff[1];
      hold_ff[1] <= (mode == DGS_DDR) ? gear_ff[2] : gear_ff[0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dq_out_ff <= 1'b0;
    end else if (mode == DGS_SDR) begin
      if (!ctrl_ff[`DGS_F_LATCH] && pop) begin
        dq_out_ff <= head[3];
      end else if (ctrl_ff[`DGS_F_LATCH] && gclk_a_ff && pop) begin
        dq_out_ff <= head[3];
      end
    end else if (mode == DGS_DDR) begin
      dq_out_ff <= ph[0] ? gear_ff[3] : hold_ff[1];
    end else begin
      case (ph)
        2'h1: dq_out_ff <= gear_ff[3];
        2'h2: dq_out_ff <= gear_ff[2];
        2'h3: dq_out_ff <= hold_ff[0];
        default: dq_out_ff <= hold_ff[1];
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dq_oe_n_ff <= 1'b1;
    end else begin
      dq_oe_n_ff <= !(en && (word_vld_ff || pop));
    end
  end

  // Strobe pin synchroniser
  logic dqs_s1_ff;
  logic dqs_s2_ff;
  logic dqs_s3_ff;
  logic dqs_rise;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dqs_s1_ff <= 1'b0;
      dqs_s2_ff <= 1'b0;
      dqs_s3_ff <= 1'b0;
    end else begin
      dqs_s1_ff <= dqs_in;
      dqs_s2_ff <= dqs_s1_ff;
      dqs_s3_ff <= dqs_s2_ff;
    end
  end

  assign dqs_rise = dqs_s2_ff && !dqs_s3_ff;

  // Delay-locked loops, one per side, stepping toward a quarter period
  logic [7:0] per_cnt_ff;
  logic [6:0] code_ff [2];
  logic [6:0] target;
  logic [6:0] dll_delay_code;
  logic lock_ff;

  assign target = {1'b0, per_cnt_ff[7:2]};
  assign dll_delay_code = code_ff[side_r];

  always_ff @(posedge clk) begin
    if (!rst_n || dqs_rise) begin
      per_cnt_ff <= 8'h1;
    end else if (per_cnt_ff != `DGS_PER_MAX) begin
      per_cnt_ff <= per_cnt_ff + 8'h1;
    end
  end

  for (genvar s = 0; s < 2; s++) begin : g_dll
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        code_ff[s] <= 7'h0;
      end else if (dqs_rise && side_r == 1'(s)) begin
        if (code_ff[s] < target) begin
          code_ff[s] <= code_ff[s] + 7'h1;
        end else if (code_ff[s] > target) begin
          code_ff[s] <= code_ff[s] - 7'h1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lock_ff <= 1'b0;
    end else if (dqs_rise) begin
      lock_ff <= dll_delay_code == target;
    end
  end

  // Read strobe control
  logic [`DGS_RD_TAPS-1:0] rd_line_ff;
  logic rd_dly_ff;
  logic rd_dly_q_ff;
  logic pol_ff;
  logic xfer_ff;
  logic xfer_tog_ff;
  logic rd_rise;

  assign rd_rise = rd_dly_ff && !rd_dly_q_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_line_ff <= '0;
      rd_dly_ff <= 1'b0;
      rd_dly_q_ff <= 1'b0;
    end else begin
      rd_line_ff <= {rd_line_ff[`DGS_RD_TAPS-2:0], dqs_s2_ff};
      rd_dly_ff <= rd_line_ff[dll_delay_code];
      rd_dly_q_ff <= rd_dly_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pol_ff <= 1'b0;
    end else if (rd_rise) begin
      pol_ff <= gclk_a_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      xfer_ff <= 1'b0;
      xfer_tog_ff <= 1'b0;
    end else begin
      xfer_tog_ff <= xfer_tog_ff ^ rd_rise;
      xfer_ff <= rd_rise && xfer_tog_ff && mode == DGS_GEAR;
    end
  end

  // Write strobe control
  logic [`DGS_WR_TAPS-1:0] wr_line_ff;
  logic [7:0] wr_tap;
  logic wstrobe_ff;
  logic dqs_out_ff;
  logic dqs_oe_n_ff;

  assign wr_tap = {1'b0, dll_delay_code} + {1'b0, dynamic_delay_setting_ff[6:0]};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_line_ff <= '0;
      wstrobe_ff <= 1'b0;
    end else begin
      wr_line_ff <= {wr_line_ff[`DGS_WR_TAPS-2:0], gclk_a_ff};
      wstrobe_ff <= wr_line_ff[wr_tap] ^ dynamic_delay_setting_ff[7];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dqs_out_ff <= 1'b0;
      dqs_oe_n_ff <= 1'b1;
    end else begin
      dqs_out_ff <= wstrobe_ff;
      dqs_oe_n_ff <= dq_oe_n_ff;
    end
  end

  assign stat_word = {21'h0, mode, lock_ff, pol_ff, dll_delay_code};

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign in_ready = in_ready_ff;
  assign dq_out = dq_out_ff;
  assign dq_oe_n = dq_oe_n_ff;
  assign dqs_out = dqs_out_ff;
  assign dqs_oe_n = dqs_oe_n_ff;
  assign write_gear_clk_a = gclk_a_ff;
  assign write_gear_clk_b = gclk_b_ff;
  assign read_strobe_delayed_clk = rd_dly_ff;
  assign capture_clock_polarity = pol_ff;
  assign gearbox_transfer_latch = xfer_ff;
  assign write_strobe_clock = wstrobe_ff;

  // Checks
  property p_bottom_sdr;
    @(posedge clk) disable iff (!rst_n)
    dgs_edge_t'(ctrl_ff[`DGS_F_EDGE_LO +: 2]) == DGS_BOTTOM |-> mode == DGS_SDR;
  endproperty
  a_bottom_sdr: assert property (p_bottom_sdr) else $error("bottom edge left SDR");

  property p_top_nogear;
    @(posedge clk) disable iff (!rst_n)
    dgs_edge_t'(ctrl_ff[`DGS_F_EDGE_LO +: 2]) == DGS_TOP |-> mode != DGS_GEAR;
  endproperty
  a_top_nogear: assert property (p_top_nogear) else $error("top edge in gearbox");

  property p_sdr_flop;
    @(posedge clk) disable iff (!rst_n)
    (mode == DGS_SDR && !ctrl_ff[`DGS_F_LATCH] && pop) ##1 (mode == DGS_SDR) |-> dq_out_ff == $past(head[3]);
  endproperty
  a_sdr_flop: assert property (p_sdr_flop) else $error("SDR data not passed");

  sequence s_ddr_load;
    mode == DGS_DDR && pop;
  endsequence
  property p_ddr_hold;
    @(posedge clk) disable iff (!rst_n)
    s_ddr_load ##1 (mode == DGS_DDR) [*2] |-> hold_ff[1] == $past(head[2], 2);
  endproperty
  a_ddr_hold: assert property (p_ddr_hold) else $error("DDR value not latched");

  property p_ddr_mux;
    @(posedge clk) disable iff (!rst_n)
    (mode == DGS_DDR && ph[0]) ##1 (mode == DGS_DDR) |-> dq_out_ff == $past(gear_ff[3]);
  endproperty
  a_ddr_mux: assert property (p_ddr_mux) else $error("DDR mux wrong");

  property p_gear_clk;
    @(posedge clk) disable iff (!rst_n)
    ph == 2'h3 |=> ph == 2'h0 ##1 ph == 2'h1 ##1 ph == 2'h2;
  endproperty
  a_gear_clk: assert property (p_gear_clk) else $error("gearing clocks out of step");

  property p_rd_delay;
    @(posedge clk) disable iff (!rst_n)
    $stable(dll_delay_code) |=> rd_dly_ff == $past(rd_line_ff[dll_delay_code]);
  endproperty
  a_rd_delay: assert property (p_rd_delay) else $error("read strobe delay wrong");

  property p_xfer_gear;
    @(posedge clk) disable iff (!rst_n)
    xfer_ff |-> $past(mode) == DGS_GEAR && $past(rd_rise);
  endproperty
  a_xfer_gear: assert property (p_xfer_gear) else $error("transfer latch outside gearbox");

  property p_wr_invert;
    @(posedge clk) disable iff (!rst_n)
    $stable(wr_tap) && $stable(dynamic_delay_setting_ff) |=>
      wstrobe_ff == ($past(wr_line_ff[wr_tap]) ^ $past(dynamic_delay_setting_ff[7]));
  endproperty
  a_wr_invert: assert property (p_wr_invert) else $error("write strobe phase wrong");

  property p_code_step;
    @(posedge clk) disable iff (!rst_n)
    !dqs_rise |=> $stable(code_ff[0]) && $stable(code_ff[1]);
  endproperty
  a_code_step: assert property (p_code_step) else $error("DLL code moved without strobe");

endmodule

// file: common/dgs_defs.svh
// Constants for the DDR edge I/O gearing and strobe delay block
// Behaviour
// - Left, right, top edges: SDR and DDR outputs.
// - Bottom edge: single data rate outputs only.
// - SDR data through one flop or latch.
// - DDR registers two inputs, latches one later.
// - Clocked mux alternates the two DDR values.
// - Gearbox registers four streams, serialises via clocks.
// - Gearing clocks move data into edge domain.
// - Left DLL banks 0,7,6; right 1,2,3.
// - DLL tracks drift, gives 7-bit code.
// - Pad strobe passes read/write strobe control.
// - Read strobe delayed 90 degrees to pads.
// - Read control sets capture clock polarity.
// - Gearbox mode makes transfer latch pulse.
// - Write control makes both gearing clocks.
// - Dynamic setting adds 128 write delay steps.
// - Setting MSB inverts strobe, half-cycle shift.
`ifndef DGS_DEFS_SVH
`define DGS_DEFS_SVH
`define DGS_ADDR_CTRL 12'h000
`define DGS_ADDR_DYN 12'h004
`define DGS_ADDR_STAT 12'h008
`define DGS_CTRL_RST 32'h0000_0000
`define DGS_DYN_RST 8'h00
`define DGS_RD_TAPS 128
`define DGS_WR_TAPS 256
`define DGS_PER_MAX 8'hff
`define DGS_F_LATCH 2
`define DGS_F_EDGE_LO 3
`define DGS_F_BANK_LO 5
`define DGS_F_EN 8
`define DGS_S_POL 7
`define DGS_S_LOCK 8
`define DGS_S_MODE_LO 9
`endif

// file: common/dgs_pkg.sv
// Types for the DDR edge I/O gearing and strobe delay block
package dgs_pkg;
  typedef enum logic [1:0] {DGS_SDR, DGS_DDR, DGS_GEAR, DGS_RSV} dgs_mode_t;
  typedef enum logic [1:0] {DGS_LEFT, DGS_RIGHT, DGS_TOP, DGS_BOTTOM} dgs_edge_t;
endpackage

// file: bench/dgs_mem_model.sv
// Memory device model: read strobe bursts toward the edge I/O block
`timescale 1ns/1ps
module dgs_mem_model (
  // Burst request from the bench
  input wire logic burst,
  // Strobe driven by the memory
  output logic dqs_rd
);
  // Strobe stands low between bursts, toggles every 200 ns within them
  initial begin
    dqs_rd = 1'b0;
    forever begin
      wait (burst === 1'b1);
      #137;
      while (burst === 1'b1) begin
        dqs_rd = 1'b1;
        #200;
        dqs_rd = 1'b0;
        #200;
      end
    end
  end
endmodule

// file: bench/dgs_top_tb.sv
// Self-checking bench for the DDR edge I/O gearing and strobe delay block
`timescale 1ns/1ps
`include "dgs_defs.svh"
`define CHK(g, x) begin checks++; if ((g) !== (x)) begin mismatches++; \
  $display("mismatch at %0t got %h exp %h", $time, g, x); end end
module dgs_top_tb;
  import dgs_pkg::*;
  logic clk, pready, pslverr, e, in_ready, dq_out, dq_oe_n, dqs_out, dqs_oe_n, dqs_rd, dqs_in;
  logic rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, in_valid = 1'b0, burst = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [3:0] wd = 4'h0, wv;
  logic gca, gcb, rsdc, ccp, gtl, wsc, x0, pb;
  logic wx [3];
  logic [7:0] dv [3] = '{8'h00, 8'h80, 8'h01};
  logic [1:0] md [6] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h2, 2'h0};
  logic [1:0] ed [6] = '{2'h0, 2'h0, 2'h0, 2'h3, 2'h2, 2'h1};
  logic [1:0] ef [6] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h0};
  // {bank, SDR latch mode} per case
  logic [3:0] xb [6] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h5};
  int mismatches = 0, checks = 0, seed = 32'h3580, n, d, p;
  // Strobe pin level from both drivers
  assign dqs_in = (dqs_oe_n === 1'b0) ? dqs_out : dqs_rd;
  dgs_top uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .out_pos_data_a(wd[3]), .out_neg_data_a(wd[2]), .out_pos_data_b(wd[1]), .out_neg_data_b(wd[0]),
    .in_valid(in_valid), .in_ready(in_ready), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .dqs_in(dqs_in), .dqs_out(dqs_out), .dqs_oe_n(dqs_oe_n), .write_gear_clk_a(gca),
    .write_gear_clk_b(gcb), .read_strobe_delayed_clk(rsdc), .capture_clock_polarity(ccp),
    .gearbox_transfer_latch(gtl), .write_strobe_clock(wsc));
  dgs_mem_model mem (.burst(burst), .dqs_rd(dqs_rd));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task close_out;
    begin
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  // Bits sent per word in each effective mode
  function automatic int nbits(input logic [1:0] m);
    return (m == 2'h0) ? 1 : (m == 2'h1) ? 2 : 4;
  endfunction
  task tick;
    begin
      @(posedge clk);
      #1;
    end
  endtask
  task tmo(input int k);
    if (k >= 50) begin
      mismatches++;
      close_out;
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wdat);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wdat;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (pready !== 1'b1 && n < 50);
      tmo(n);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rst_dut;
    begin
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
    end
  endtask
  task send(input logic [3:0] v);
    begin
      @(posedge clk);
      wd <= v;
      in_valid <= 1'b1;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (in_ready !== 1'b1 && n < 50);
      tmo(n);
      in_valid <= 1'b0;
    end
  endtask
  initial begin
    rst_dut;
    apb(1'b0, `DGS_ADDR_CTRL, 32'h0);
    `CHK(r, `DGS_CTRL_RST)
    apb(1'b0, 12'h00c, 32'h0);
    `CHK({e, r}, 33'h1_0000_0000)
    apb(1'b1, `DGS_ADDR_STAT, 32'hffff_ffff);
    `CHK(e, 1'b1)
    d = $random(seed);
    apb(1'b1, `DGS_ADDR_DYN, d);
    apb(1'b0, `DGS_ADDR_DYN, 32'h0);
    `CHK(r, {24'h0, d[7:0]})
    $display("registers done");
    tick;
    x0 = gca;
    pb = gcb;
    p = 0;
    repeat (8) begin
      tick;
      `CHK(gca, ~x0)
      x0 = gca;
      p += (gcb !== pb);
      pb = gcb;
    end
    `CHK(p, 4)
    $display("gear clocks done");
    // Controller picks the write-leveling setting
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `DGS_ADDR_DYN, {24'h0, dv[i]});
      repeat (40) tick;
      wx[i] = wsc ^ gca;
      x0 = wsc;
      tick;
      `CHK(dqs_out, x0)
    end
    `CHK(wx[1], ~wx[0])
    `CHK(wx[2], ~wx[0])
    $display("write strobe done");
    p = 0;
    @(posedge clk);
    in_valid <= 1'b1;
    repeat (10) begin
      @(posedge clk);
      if (in_ready === 1'b1) p++;
      wd <= 4'($random(seed));
    end
    in_valid <= 1'b0;
    `CHK(p, 2)
    apb(1'b1, `DGS_ADDR_CTRL, 32'h100);
    n = 0;
    while (in_ready !== 1'b1 && n < 50) begin
      tick;
      n++;
    end
    tmo(n);
    $display("buffer done");
    for (int i = 0; i < 6; i++) begin
      rst_dut;
      apb(1'b1, `DGS_ADDR_CTRL, {23'h0, 1'b1, xb[i][3:1], ed[i], xb[i][0], md[i]});
      wv = 4'($random(seed));
      send(wv);
      n = 0;
      while (dq_oe_n !== 1'b0 && n < 50) begin
        tick;
        n++;
      end
      tmo(n);
      if (ef[i] != 2'h0) tick;
      for (int j = 0; j < nbits(ef[i]); j++) begin
        `CHK(dq_out, wv[3 - j])
        tick;
      end
      `CHK(dqs_oe_n, 1'b0)
      apb(1'b0, `DGS_ADDR_STAT, 32'h0);
      `CHK(r[10:9], ef[i])
      @(posedge clk);
      burst <= 1'b1;
      p = 0;
      repeat (64) begin
        tick;
        p += (gtl === 1'b1);
      end
      // Next strobe rise from the memory, bounded
      n = 0;
      while (dqs_rd !== 1'b0 && n < 50) begin
        tick;
        n++;
      end
      while (dqs_rd !== 1'b1 && n < 50) begin
        tick;
        n++;
      end
      tmo(n);
      d = 0;
      while (rsdc !== 1'b0 && d < 20) begin
        tick;
        d++;
      end
      while (rsdc !== 1'b1 && d < 20) begin
        tick;
        d++;
      end
      `CHK(d inside {[5:7]}, 1'b1)
      x0 = gca;
      tick;
      `CHK(ccp, x0)
      @(posedge clk);
      burst <= 1'b0;
      apb(1'b0, `DGS_ADDR_STAT, 32'h0);
      `CHK(r[6:0], 7'h2)
      `CHK((ef[i] == 2'h2) ? (p inside {[3:5]}) : (p == 0), 1'b1)
      $display("mode case %0d done", i);
    end
    close_out;
  end
endmodule
